/* File: core/tdt_top.sv */
/*
  Tap and double-tap detector with activity chaining and auto sleep,
  behind an AXI4-Lite register slave.
  Assumes samples and event pulses synchronous to core_clk_i, and a
  sample tick of one cycle per internal sample period.
*/
`timescale 1ns/10ps
module tdt_top (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        smp_tick_i,
  input  wire logic [15:0] sample_x_i,
  input  wire logic [15:0] sample_y_i,
  input  wire logic [15:0] sample_z_i,
  input  wire logic        act_event_i,
  input  wire logic        inact_event_i,
  output logic             irq_pin_a_o,
  output logic             irq_pin_b_o,
  output logic             auto_sleep_o,
  output logic             odr_tick_o
);
  import tdt_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic              awready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [31:0]       cfg;
    logic [31:0]       ctrl;
    logic [3:0]        map;
    logic [3:0]        flags;
    logic [2:0]        first_axis;
    logic              auto_sleep_flag;
    logic              armed;
    tdt_tap_state_type st;
    logic [7:0]        cnt;
    logic [2:0]        cand;
    logic              irq_a;
    logic              irq_b;
  } tdt_top_state_type;

  tdt_top_state_type state;
  tdt_top_state_type next_state;

  logic [7:0] thr;
  logic [7:0] max_len;
  logic [7:0] gap;
  logic [7:0] span;
  logic [2:0] above;
  logic       any_high;
  logic       en_sgl;
  logic       dbl_ok;
  logic       wr_go;
  logic       rd_go;
  logic       act_ok;
  logic       inact_ok;
  logic       sgl_ev;
  logic       dbl_ev;
  logic [3:0] clr_flags;
  logic [3:0] set_flags;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // ****************************************
  // Settings and submodules
  // ****************************************
  assign thr     = state.cfg[CFG_THR_LSB +: 8];
  assign max_len = state.cfg[CFG_LEN_LSB +: 8];
  assign gap     = state.cfg[CFG_GAP_LSB +: 8];
  assign span    = state.cfg[CFG_SPAN_LSB +: 8];
  assign en_sgl  = state.ctrl[CTL_SGL_EN];
  assign dbl_ok  = state.ctrl[CTL_DBL_EN] && (gap != 8'h00)
                   && (span != 8'h00);
  assign any_high = |above;

  // Raw samples against threshold, per selected axis
  tdt_axis_cmp u_cmp (
    .sample_x_i (sample_x_i),
    .sample_y_i (sample_y_i),
    .sample_z_i (sample_z_i),
    .thr_i      (thr),
    .axes_i     (state.ctrl[CTL_AXES_LSB +: 3]),
    .above_o    (above)
  );

  // Output rate tick from the common sample tick
  tdt_decim u_decim (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .smp_tick_i (smp_tick_i),
    .ratio_i    (state.ctrl[CTL_DEC_LSB +: 4]),
    .odr_tick_o (odr_tick_o)
  );

  // Bus starts and chained activity qualification
  assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !state.awready
                 && !state.bvalid;
  assign rd_go = s_axi_arvalid_i && !state.arready && !state.rvalid;
  assign act_ok = act_event_i && state.ctrl[CTL_ACT_EN]
                  && (!state.ctrl[CTL_LINK] || state.armed);
  assign inact_ok = inact_event_i && state.ctrl[CTL_INACT_EN]
                    && (!state.ctrl[CTL_LINK] || !state.armed);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state = state;
    sgl_ev     = 1'b0;
    dbl_ev     = 1'b0;
    clr_flags  = 4'h0;
    set_flags  = 4'h0;

    // Write channel: raise ready, then apply at the handshake
    next_state.awready = wr_go;
    if (state.awready) begin
      next_state.bvalid = 1'b1;
      next_state.bresp  = RESP_OKAY;
      if (s_axi_awaddr_i == OFS_TAP_CFG) begin
        next_state.cfg = merge_bytes(state.cfg, s_axi_wdata_i,
                                     s_axi_wstrb_i);
      end else if (s_axi_awaddr_i == OFS_CTRL) begin
        next_state.ctrl = merge_bytes(state.ctrl, s_axi_wdata_i,
                                      s_axi_wstrb_i);
      end else if (s_axi_awaddr_i == OFS_INT_MAP) begin
        if (s_axi_wstrb_i[0]) begin
          next_state.map = s_axi_wdata_i[3:0];
        end
      end else if (s_axi_awaddr_i == OFS_INT_SRC) begin
        next_state.bresp = RESP_OKAY;
      end else if (s_axi_awaddr_i == OFS_REPORT) begin
        next_state.bresp = RESP_OKAY;
      end else begin
        next_state.bresp = RESP_SLVERR;
      end
    end else if (state.bvalid && s_axi_bready_i) begin
      next_state.bvalid = 1'b0;
    end

    // Read channel: data and side effects at the handshake
    next_state.arready = rd_go;
    if (state.arready) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = RESP_OKAY;
      if (s_axi_araddr_i == OFS_TAP_CFG) begin
        next_state.rdata = state.cfg;
      end else if (s_axi_araddr_i == OFS_CTRL) begin
        next_state.rdata = state.ctrl;
      end else if (s_axi_araddr_i == OFS_INT_MAP) begin
        next_state.rdata = {28'h000_0000, state.map};
      end else if (s_axi_araddr_i == OFS_INT_SRC) begin
        next_state.rdata = {28'h000_0000, state.flags};
        clr_flags = 4'hF;
      end else if (s_axi_araddr_i == OFS_REPORT) begin
        next_state.rdata = {28'h000_0000, state.auto_sleep_flag,
                            state.first_axis};
      end else begin
        next_state.rdata = 32'h0000_0000;
        next_state.rresp = RESP_SLVERR;
      end
    end else if (state.rvalid && s_axi_rready_i) begin
      next_state.rvalid = 1'b0;
    end

    // Tap sequencer, one step per sample tick
    if (smp_tick_i) begin
      case (state.st)
        TS_IDLE: begin
          if (any_high && (en_sgl || state.ctrl[CTL_DBL_EN])) begin
            next_state.st   = TS_TAP1;
            next_state.cnt  = 8'h01;
            next_state.cand = 3'(above & (~above + 3'h1));
          end
        end
        TS_TAP1: begin
          if (any_high) begin
            if (state.cnt >= max_len) begin
              next_state.st = TS_DROP;
            end else begin
              next_state.cnt = 8'(state.cnt + 8'h01);
            end
          end else if (dbl_ok) begin
            next_state.st  = TS_GAP;
            next_state.cnt = 8'h00;
          end else begin
            sgl_ev        = en_sgl;
            next_state.st = TS_IDLE;
          end
        end
        TS_GAP: begin
          if (any_high && state.ctrl[CTL_VETO]) begin
            sgl_ev        = en_sgl;
            next_state.st = TS_DROP;
          end else if (state.cnt == 8'(gap - 8'h01)) begin
            next_state.st  = TS_SPAN;
            next_state.cnt = 8'h00;
          end else begin
            next_state.cnt = 8'(state.cnt + 8'h01);
          end
        end
        TS_SPAN: begin
          if (any_high && state.cnt == 8'h00) begin
            sgl_ev        = en_sgl;
            next_state.st = TS_DROP;
          end else if (any_high) begin
            next_state.st  = TS_TAP2;
            next_state.cnt = 8'h01;
          end else if (state.cnt == 8'(span - 8'h01)) begin
            sgl_ev        = en_sgl;
            next_state.st = TS_IDLE;
          end else begin
            next_state.cnt = 8'(state.cnt + 8'h01);
          end
        end
        TS_TAP2: begin
          if (any_high) begin
            if (state.cnt >= max_len) begin
              sgl_ev        = en_sgl;
              next_state.st = TS_DROP;
            end else begin
              next_state.cnt = 8'(state.cnt + 8'h01);
            end
          end else begin
            dbl_ev        = 1'b1;
            sgl_ev        = en_sgl;
            next_state.st = TS_IDLE;
          end
        end
        TS_DROP: begin
          if (!any_high) begin
            next_state.st = TS_IDLE;
          end
        end
        default: begin
          next_state.st = TS_IDLE;
        end
      endcase
    end

    // First-axis record, overwritten on each tap event
    if (sgl_ev || dbl_ev) begin
      next_state.first_axis = state.cand;
    end

    // Chaining and auto sleep
    if (act_ok) begin
      next_state.armed  = 1'b0;
      next_state.auto_sleep_flag = 1'b0;
    end else if (inact_ok) begin
      next_state.armed = 1'b1;
      if (state.ctrl[CTL_ASLP_EN] && !state.flags[FLG_ACT]) begin
        next_state.auto_sleep_flag = 1'b1;
      end
    end
    if (!state.ctrl[CTL_ASLP_EN]) begin
      next_state.auto_sleep_flag = 1'b0;
    end

    // Sticky flags, a new event wins over a read clear
    set_flags[FLG_SGL]   = sgl_ev;
    set_flags[FLG_DBL]   = dbl_ev;
    set_flags[FLG_ACT]   = act_ok;
    set_flags[FLG_INACT] = inact_ok;
    next_state.flags = (state.flags & ~clr_flags) | set_flags;

    // Pin routing by map bit, ORed per pin
    next_state.irq_a = |(next_state.flags & ~next_state.map);
    next_state.irq_b = |(next_state.flags & next_state.map);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state      <= '0;
      state.st   <= TS_IDLE;
      state.cfg  <= CFG_RST;
      state.ctrl <= CTRL_RST;
      state.map  <= MAP_RST;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready_o = state.awready;
  assign s_axi_wready_o  = state.awready;
  assign s_axi_bvalid_o  = state.bvalid;
  assign s_axi_bresp_o   = state.bresp;
  assign s_axi_arready_o = state.arready;
  assign s_axi_rvalid_o  = state.rvalid;
  assign s_axi_rresp_o   = state.rresp;
  assign s_axi_rdata_o   = state.rdata;
  assign irq_pin_a_o     = state.irq_a;
  assign irq_pin_b_o     = state.irq_b;
  assign auto_sleep_o    = state.auto_sleep_flag;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  AST_NO_CANDIDATE: assert property (
    state.st == TS_IDLE && smp_tick_i && !any_high
    |=> state.st == TS_IDLE)
    else $error("tap started without a high sample");

  AST_TAP1_TOO_LONG: assert property (
    state.st == TS_TAP1 && smp_tick_i && any_high
    && state.cnt >= max_len |=> state.st == TS_DROP)
    else $error("overlong first tap not dropped");

  AST_GAP_HOLDS: assert property (
    state.st == TS_GAP && smp_tick_i && !any_high
    && state.cnt != 8'(gap - 8'h01) |=> state.st == TS_GAP)
    else $error("quiet gap left early");

  AST_SPAN_START: assert property (
    state.st == TS_SPAN && smp_tick_i && any_high
    && state.cnt != 8'h00 |=> state.st == TS_TAP2 ##0 state.cnt == 8'h01)
    else $error("second tap in span not taken");

  AST_SINGLE_ONLY: assert property (
    state.st == TS_TAP1 && smp_tick_i && !any_high && en_sgl && !dbl_ok
    |=> state.flags[FLG_SGL] && state.st == TS_IDLE)
    else $error("single tap not flagged at release");

  AST_VETO: assert property (
    state.st == TS_GAP && smp_tick_i && any_high && state.ctrl[CTL_VETO]
    |=> state.st == TS_DROP)
    else $error("spike in quiet gap not vetoed");

  AST_OPEN_HIGH: assert property (
    state.st == TS_SPAN && smp_tick_i && any_high && state.cnt == 8'h00
    |=> state.st == TS_DROP)
    else $error("high at span open not rejected");

  AST_TAP2_TOO_LONG: assert property (
    state.st == TS_TAP2 && smp_tick_i && any_high && state.cnt >= max_len
    |=> state.st == TS_DROP && state.flags[FLG_SGL] == $past(en_sgl))
    else $error("overlong second tap not rejected");

  AST_DOUBLE: assert property (
    state.st == TS_TAP2 && smp_tick_i && !any_high
    |=> state.flags[FLG_DBL] && state.first_axis == $past(state.cand))
    else $error("valid double tap not flagged");

  AST_NO_SLEEP_ACT: assert property (
    state.flags[FLG_ACT] && !state.auto_sleep_flag |=> !state.auto_sleep_flag)
    else $error("auto sleep with activity pending");

  AST_READ_CLEAR: assert property (
    state.arready && s_axi_araddr_i == OFS_INT_SRC && !sgl_ev && !dbl_ev
    |=> !state.flags[FLG_SGL] && !state.flags[FLG_DBL])
    else $error("tap flags survive source read");

  AST_PIN_ROUTE: assert property (
    ##1 irq_pin_b_o == |(state.flags & state.map)
    && irq_pin_a_o == |(state.flags & ~state.map))
    else $error("interrupt pin routing wrong");

endmodule : tdt_top

/* File: core/tdt_pkg.sv */
/*
  Constants for the tap and double-tap detector: register offsets, field
  positions, reset values, bus answers and the tap sequencer states.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses and one
  tick per internal sample from the sensor front end.
*/
package tdt_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_TAP_CFG  = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_INT_MAP  = 8'h08;
  localparam logic [7:0] OFS_INT_SRC  = 8'h0C;
  localparam logic [7:0] OFS_REPORT   = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_THR_LSB  = 0;
  localparam int CFG_LEN_LSB  = 8;
  localparam int CFG_GAP_LSB  = 16;
  localparam int CFG_SPAN_LSB = 24;
  localparam int CTL_AXES_LSB = 0;
  localparam int CTL_VETO     = 3;
  localparam int CTL_SGL_EN   = 4;
  localparam int CTL_DBL_EN   = 5;
  localparam int CTL_ACT_EN   = 6;
  localparam int CTL_INACT_EN = 7;
  localparam int CTL_LINK     = 8;
  localparam int CTL_ASLP_EN  = 9;
  localparam int CTL_DEC_LSB  = 12;
  localparam int FLG_SGL      = 0;
  localparam int FLG_DBL      = 1;
  localparam int FLG_ACT      = 2;
  localparam int FLG_INACT    = 3;
  localparam int REP_ASLP     = 3;
  localparam int THR_SHIFT    = 4;

  // ****************************************
  // Reset values and bus answers
  // ****************************************
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0007;
  localparam logic [3:0]  MAP_RST  = 4'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Tap sequencer states
  typedef enum logic [2:0] {
    TS_IDLE,
    TS_TAP1,
    TS_GAP,
    TS_SPAN,
    TS_TAP2,
    TS_DROP
  } tdt_tap_state_type;

endpackage : tdt_pkg

/* File: core/tdt_axis_cmp.sv */
/*
  Per-axis threshold compare on raw samples.
  Assumes two's complement samples valid with the sample tick.
*/
`timescale 1ns/10ps
module tdt_axis_cmp (
  input  wire logic [15:0] sample_x_i,
  input  wire logic [15:0] sample_y_i,
  input  wire logic [15:0] sample_z_i,
  input  wire logic [7:0]  thr_i,
  input  wire logic [2:0]  axes_i,
  output logic      [2:0]  above_o
);
  import tdt_pkg::*;

  logic [2:0][15:0] smp;
  logic [15:0]      limit;

  assign smp   = {sample_z_i, sample_y_i, sample_x_i};
  assign limit = 16'({8'h00, thr_i} << THR_SHIFT);

  // Magnitude against threshold, masked per axis
  for (genvar g = 0; g < 3; g++) begin : g_axis
    logic [15:0] mag;
    assign mag = smp[g][15] ? 16'(~smp[g] + 16'h0001) : smp[g];
    assign above_o[g] = axes_i[g] && (mag > limit);
  end

endmodule : tdt_axis_cmp

/* File: core/tdt_decim.sv */
/*
  Output data rate tick made by decimating the sample tick.
  Assumes one sample tick per internal sample period.
*/
`timescale 1ns/10ps
module tdt_decim (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       smp_tick_i,
  input  wire logic [3:0] ratio_i,
  output logic            odr_tick_o
);
  import tdt_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } tdt_decim_state_type;

  tdt_decim_state_type state;
  tdt_decim_state_type next_state;

  // Every ratio+1 sample ticks give one output tick
  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (smp_tick_i) begin
      if (state.cnt >= ratio_i) begin
        next_state.cnt  = 4'h0;
        next_state.tick = 1'b1;
      end else begin
        next_state.cnt = 4'(state.cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign odr_tick_o = state.tick;

endmodule : tdt_decim

/* File: dv/tdt_host_model.sv */
/*
  Host model: AXI4-Lite master that services the detector registers.
  Assumes the bench calls wr and rd one at a time from one process.
*/
`timescale 1ns/10ps
module tdt_host_model (
  input  wire logic        core_clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  // Idle bus from time zero
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end

  // Write: address and data offered together, each held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk_i);
    awaddr_o  <= a;
    awvalid_o <= 1'b1;
    wdata_o   <= d;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
    end while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask : wr

  // Read: a read of the source flags is what clears them
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arready_i) arvalid_o <= 1'b0;
    end while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
endmodule : tdt_host_model

/* File: dv/tdt_top_tb.sv */
/*
  Self-checking bench for the tap detector: tap sequences against a
  queue model, flags, pins, report and chaining.
  Assumes thr=2 so a high sample has magnitude above 32.
*/
`timescale 1ns/10ps
module tdt_top_tb;
  import tdt_pkg::*;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, smp_tick_i = 1'b0;
  logic act_event_i = 1'b0, inact_event_i = 1'b0;
  logic [15:0] sample_x_i = '0, sample_y_i = '0, sample_z_i = '0;
  logic [7:0] awa, ara;
  logic [31:0] wd, s_axi_rdata_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic awv, s_axi_awready_o, wv, s_axi_wready_o, s_axi_bvalid_o, br;
  logic arv, s_axi_arready_o, s_axi_rvalid_o, rr;
  logic irq_pin_a_o, irq_pin_b_o, auto_sleep_o, odr_tick_o;
  int mismatches = 0, samples_checked = 0;
  int odr_seen = 0, odr_base = 0;

  tdt_top DUT (.core_clk_i, .rstn_i, .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o, .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i(rr),
    .smp_tick_i, .sample_x_i, .sample_y_i, .sample_z_i, .act_event_i,
    .inact_event_i, .irq_pin_a_o, .irq_pin_b_o, .auto_sleep_o,
    .odr_tick_o);
  tdt_host_model host (.core_clk_i, .awaddr_o(awa), .awvalid_o(awv),
    .awready_i(s_axi_awready_o), .wdata_o(wd), .wvalid_o(wv),
    .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
    .bvalid_i(s_axi_bvalid_o), .bready_o(br), .araddr_o(ara),
    .arvalid_o(arv), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(rr));

  // Clock and hang watchdog
  always #5 core_clk_i = ~core_clk_i;

  // Output rate pulses seen
  always @(posedge core_clk_i) begin
    if (odr_tick_o) odr_seen++;
  end
  initial begin
    #200_000;
    mismatches++;
    test_done();
  end

  // ****************************************
  // Checking helpers and tap model
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // One sample tick, chosen axis high or low, others low
  task automatic tick(input int ax, input int hi);
    logic [15:0] v[3];
    for (int k = 0; k < 3; k++) v[k] = 16'($urandom_range(0, 64)) - 16'd32;
    if (hi == 1) v[ax] = 16'($urandom_range(33, 3000));
    if (hi == 1 && $urandom_range(0, 1) == 1) v[ax] = -v[ax];
    @(posedge core_clk_i);
    smp_tick_i <= 1'b1;
    sample_x_i <= v[0];
    sample_y_i <= v[1];
    sample_z_i <= v[2];
    @(posedge core_clk_i);
    smp_tick_i <= 1'b0;
  endtask : tick

  // Expected {double, single} flags for a high/low tick queue, len 3
  function automatic logic [1:0] model(int q[$], int g, int s,
                                       logic [15:0] c);
    int i = 0, n = 0, m = 0;
    while (q[i] == 1) begin
      n++;
      i++;
    end
    if (n == 0 || n > 3) return 2'b00;
    if (!c[5] || g == 0 || s == 0) return {1'b0, c[4]};
    for (int k = 1; k <= g; k++) begin
      if (c[3] && q[i+k] == 1) return {1'b0, c[4]};
    end
    i = i + g + 1;
    if (q[i] == 1) return {1'b0, c[4]};
    for (int k = 1; k < s && m == 0; k++) while (q[i+k+m] == 1) m++;
    return {m > 0 && m <= 3, c[4]};
  endfunction : model

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    static logic [63:0] rows[10] = '{64'h0003_0203_0017_0000,
      64'h000F_0203_0017_0001, 64'h0043_0203_0037_0002,
      64'h000B_0203_003F_0000, 64'h0023_0203_0037_0301,
      64'h03C3_0203_0037_0000, 64'h0043_0003_0037_0000,
      64'h0003_0203_0011_0001, 64'h0043_0203_0027_0302,
      64'h0203_0203_0037_0000};
    int q[$];
    int ax;
    logic [1:0] f, mp;
    logic [15:0] c;
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(74));
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    host.rd(OFS_CTRL, d, r);
    chk(d, CTRL_RST);
    host.rd(8'h40, d, r);
    chk({d[29:0], r}, {30'd0, RESP_SLVERR});
    host.wr(8'h40, 32'hFFFF_FFFF, r);
    chk({30'd0, r}, {30'd0, RESP_SLVERR});
    foreach (rows[n]) begin
      c  = rows[n][31:16];
      mp = rows[n][9:8];
      ax = int'(rows[n][7:0]);
      host.wr(OFS_TAP_CFG, {rows[n][39:32], rows[n][47:40], 16'h0302}, r);
      host.wr(OFS_CTRL, {16'h0000, c}, r);
      host.wr(OFS_INT_MAP, {30'd0, mp}, r);
      q = {};
      for (int t = 0; t < 32; t++) q.push_back(t < 16 && rows[n][48+t]);
      foreach (q[t]) tick(ax, q[t]);
      if (!c[ax]) q = {0};
      f = model(q, rows[n][47:40], rows[n][39:32], c);
      chk({31'd0, irq_pin_a_o}, {31'd0, |(f & ~mp)});
      chk({31'd0, irq_pin_b_o}, {31'd0, |(f & mp)});
      host.rd(OFS_INT_SRC, d, r);
      chk(d, {30'd0, f});
      if (f != 2'b00) host.rd(OFS_REPORT, d, r);
      if (f != 2'b00) chk({29'd0, d[2:0]}, 32'd1 << ax);
      host.rd(OFS_INT_SRC, d, r);
      chk(d, 32'd0);
    end
    // Long gap and span, double tap on the second span tick
    host.wr(OFS_TAP_CFG, 32'h1111_0302, r);
    host.wr(OFS_CTRL, 32'h0000_0037, r);
    q = {1, 1};
    for (int t = 0; t < 40; t++) q.push_back(t == 19);
    foreach (q[t]) tick(0, q[t]);
    f = model(q, 17, 17, 16'h0037);
    host.rd(OFS_INT_SRC, d, r);
    chk(d, {30'd0, f});
    // Chaining: inact, act, inact with act pending, act, act unarmed
    host.wr(OFS_CTRL, 32'h0000_03C7, r);
    for (int e = 0; e < 5; e++) begin
      @(posedge core_clk_i);
      act_event_i   <= (e == 1 || e >= 3);
      inact_event_i <= (e == 0 || e == 2);
      @(posedge core_clk_i);
      {act_event_i, inact_event_i} <= 2'b00;
      repeat (3) @(posedge core_clk_i);
      if (e == 0) chk({31'd0, auto_sleep_o}, 32'd1);
      if (e == 0) host.rd(OFS_REPORT, d, r);
      if (e == 0) chk(d, 32'h0000_0009);
      if (e == 1) chk({31'd0, auto_sleep_o}, 32'd0);
      if (e == 2) chk({31'd0, auto_sleep_o}, 32'd0);
      if (e >= 2) host.rd(OFS_INT_SRC, d, r);
      if (e == 2) chk(d, 32'h0000_000C);
      if (e == 3) chk(d, 32'h0000_0004);
      if (e == 4) chk(d, 32'h0000_0000);
    end
    // Decimation by four: eight sample ticks give two output ticks
    host.wr(OFS_CTRL, 32'h0000_3000, r);
    odr_base = odr_seen;
    repeat (8) tick(0, 0);
    repeat (3) @(posedge core_clk_i);
    chk(32'(odr_seen - odr_base), 32'd2);
    test_done();
  end
endmodule : tdt_top_tb
